// *** include/dacswp_consts.svh ***
// Constants for the serial DAC write port: frame layout, modes and link timing.
// Assumes a single 50 MHz system clock at both ends.
// Contract
// (R1) Host drops frame select before first edge
// (R2) Shifting only while frame select low
// (R3) Sample data on falling serial clock
// (R4) Sixteenth falling edge executes the frame
// (R5) First bit first; two leading bits ignored
// (R6) Bits 13:12 mode, then twelve code bits
// (R7) Code register loads at sixteenth edge
// (R8) Early frame select rise aborts frame
// (R9) Host may hold or raise select after
// (R10) Select high at least 33 ns between
// (R11) Host idles frame select low between frames
// (R12) Serial clock no faster than 30 MHz
// (R13) Power-up code zero, output zero volts
// (R14) Mode 00 normal,01 1k,10 100k,11 open
// (R15) Power-down disconnects amplifier from output
// (R16) Straight binary code 0 to 4095
// (R17) One-hot string tap selection
// (R18) Ignore edges after execution until reselect
// (R19) Code and mode update together
`ifndef DACSWP_CONSTS_SVH
`define DACSWP_CONSTS_SVH
`define DACSWP_FRAME_BITS     5'd16
`define DACSWP_FRAME_LAST_CNT 5'd15
`define DACSWP_MODE_HI_POS    13
`define DACSWP_MODE_LO_POS    12
`define DACSWP_CODE_MSB_POS   11
`define DACSWP_CODE_RESET     12'h000
`define DACSWP_MODE_RESET     2'h0
`define DACSWP_CLK_HZ         50000000
`define DACSWP_SCLK_MAX_HZ    30000000
`define DACSWP_SEL_HIGH_NS    33
// Host register port offsets
`define DACSWP_ADDR_CMD       2'h0
`define DACSWP_ADDR_STATUS    2'h1
// Half period in system cycles; 4 gives 6.25 MHz, well under the ceiling
`define DACSWP_HALF_CYCLES    8'd4
// Least select-high time rounded up to whole cycles (33 ns -> 2)
`define DACSWP_SEL_HIGH_CYCLES ((`DACSWP_SEL_HIGH_NS * (`DACSWP_CLK_HZ / 1000000) + 999) / 1000)
`endif

// *** include/dacswp_pkg.sv ***
// Types shared by the device end, the monitor and the bench of the serial DAC write port.
// Assumes dacswp_consts.svh is compiled alongside.
package dacswp_pkg;
  typedef enum logic [1:0] {
    DACSWP_MODE_NORMAL = 2'h0,
    DACSWP_MODE_PD_1K  = 2'h1,
    DACSWP_MODE_PD_100K= 2'h2,
    DACSWP_MODE_HIZ    = 2'h3
  } dacswp_mode_t;
endpackage : dacswp_pkg

// *** include/dacswp_if.sv ***
// Three-wire link between host and DAC serial port.
// Assumes the host drives all three wires.
`timescale 1ns/1ps
interface dacswp_if;
  logic frame_sel_n;
  logic sclk;
  logic sdata;
  modport host (output frame_sel_n, output sclk, output sdata);
  modport dev  (input frame_sel_n, input sclk, input sdata);
endinterface : dacswp_if

// *** core/dacswp_device.sv ***
// Device end: serial shift register, frame execution and output switch decode.
// Assumes link pins are asynchronous to i_mclk and sampled here.
`timescale 1ns/1ps
`include "dacswp_consts.svh"
module dacswp_device (
  // System
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  // Link
  dacswp_if.dev                      link,
  // Converter controls
  output logic [11:0]                o_code,
  output dacswp_pkg::dacswp_mode_t   o_mode,
  output logic [4095:0]              o_tap_sel,
  output logic                       o_amp_connect,
  output logic                       o_pull_1k,
  output logic                       o_pull_100k,
  output logic                       o_frame_done
);
  logic [1:0]  sel_sync_reg;
  logic [1:0]  clk_sync_reg;
  logic [1:0]  dat_sync_reg;
  logic        clk_prev_reg;
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic        done_reg;
  logic        fall;
  logic        sel_low;

  always_ff @(posedge i_mclk)
  begin
    sel_sync_reg <= {sel_sync_reg[0], link.frame_sel_n};
    clk_sync_reg <= {clk_sync_reg[0], link.sclk};
    dat_sync_reg <= {dat_sync_reg[0], link.sdata};
    clk_prev_reg <= clk_sync_reg[1];
  end

  assign sel_low = ~sel_sync_reg[1];
  assign fall    = clk_prev_reg & ~clk_sync_reg[1];  // R3

  // Shift and count; select high clears the frame
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !sel_low)  // R2 R8
    begin
      shift_reg <= 16'h0000;
      count_reg <= 5'd0;
      done_reg  <= 1'b0;
    end
    else if (fall && !done_reg)  // R18
    begin
      shift_reg <= {shift_reg[14:0], dat_sync_reg[1]};  // R3 R5
      if (count_reg == `DACSWP_FRAME_LAST_CNT)
      begin
        done_reg  <= 1'b1;  // R4
        count_reg <= 5'd0;
      end
      else
      begin
        count_reg <= count_reg + 5'd1;
      end
    end
  end

  // Execute on the 16th edge; both fields in one edge
  always_ff @(posedge i_mclk)
  begin
    o_frame_done <= 1'b0;
    if (i_rst)
    begin
      o_code <= `DACSWP_CODE_RESET;  // R13
      o_mode <= dacswp_pkg::DACSWP_MODE_NORMAL;
    end
    else if (sel_low && fall && !done_reg && count_reg == `DACSWP_FRAME_LAST_CNT)
    begin
      o_code <= {shift_reg[10:0], dat_sync_reg[1]};  // R6 R7 R16 R19
      o_mode <= dacswp_pkg::dacswp_mode_t'(shift_reg[12:11]);  // R6 R19
      o_frame_done <= 1'b1;  // R4
    end
  end

  // Output switching from the stored mode and code
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_tap_sel     <= {{4095{1'b0}}, 1'b1};  // R13
      o_amp_connect <= 1'b1;
      o_pull_1k     <= 1'b0;
      o_pull_100k   <= 1'b0;
    end
    else
    begin
      o_tap_sel     <= 4096'(1) << o_code;  // R17
      o_amp_connect <= (o_mode == dacswp_pkg::DACSWP_MODE_NORMAL);  // R14 R15
      o_pull_1k     <= (o_mode == dacswp_pkg::DACSWP_MODE_PD_1K);  // R14
      o_pull_100k   <= (o_mode == dacswp_pkg::DACSWP_MODE_PD_100K);  // R14
    end
  end
endmodule : dacswp_device

// *** core/dacswp_host.sv ***
// Host end: register port takes a 14-bit command and serialises a 16-bit frame.
// Assumes a single-master register port on i_mclk.
`timescale 1ns/1ps
`include "dacswp_consts.svh"
module dacswp_host (
  // System
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [1:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // Link
  dacswp_if.host           link
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_GAP   = 4'b1000
  } dacswp_hst_t;

  dacswp_hst_t state_reg;
  logic [15:0] word_reg;
  logic [4:0]  bit_reg;
  logic [7:0]  div_reg;
  logic        sclk_reg;
  logic        sel_n_reg;
  logic        tick;
  logic        busy;

  assign busy = (state_reg != ST_IDLE);
  assign tick = (div_reg == `DACSWP_HALF_CYCLES - 8'd1);

  // Half-period enable; R12 bound kept by the divider
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || state_reg == ST_IDLE)
      div_reg <= 8'd0;
    else if (tick)
      div_reg <= 8'd0;
    else
      div_reg <= div_reg + 8'd1;  // R12
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_reg <= ST_IDLE;
      sel_n_reg <= 1'b0;  // R11
      sclk_reg  <= 1'b1;
      bit_reg   <= 5'd0;
      word_reg  <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (i_wr && i_addr == `DACSWP_ADDR_CMD)
          begin
            word_reg  <= {2'b00, i_wdata[13:0]};  // R5
            sel_n_reg <= 1'b1;  // R10
            state_reg <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (tick)
          begin
            sel_n_reg <= 1'b0;  // R1
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (tick)
            state_reg <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (tick)
          begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg)
            begin
              bit_reg <= bit_reg + 5'd1;
            end
            else
            begin
              word_reg <= {word_reg[14:0], 1'b0};  // R5
              if (bit_reg == `DACSWP_FRAME_BITS)
              begin
                bit_reg   <= 5'd0;
                state_reg <= ST_IDLE;  // R9 R11
              end
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      o_rdata <= 32'h0000_0000;
    else if (i_rd && i_addr == `DACSWP_ADDR_STATUS)
      o_rdata <= {31'h0, busy};
    else if (i_rd && i_addr == `DACSWP_ADDR_CMD)
      o_rdata <= {18'h0, word_reg[13:0]};
    else
      o_rdata <= 32'h0000_0000;
  end

  assign link.frame_sel_n = sel_n_reg;
  assign link.sclk        = sclk_reg;
  assign link.sdata       = word_reg[15];
endmodule : dacswp_host

// *** sim/dacswp_monitor.sv ***
// Checker on the host-to-device link and the device's stored state.
// Assumes the host runs on i_mclk, so link edges are seen directly.
`timescale 1ns/1ps
module dacswp_monitor (
  // System
  input wire logic                     i_mclk,
  input wire logic                     i_rst,
  // Link and device state
  input wire logic                     frame_sel_n,
  input wire logic                     sclk,
  input wire logic [11:0]              o_code,
  input wire dacswp_pkg::dacswp_mode_t o_mode,
  input wire logic                     o_amp_connect,
  input wire logic                     o_pull_1k,
  input wire logic                     o_pull_100k,
  input wire logic                     o_frame_done
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [4:0] n_fall;
  logic       spent;
  // Falls in the current frame; a raised select starts the count again
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || frame_sel_n)
      n_fall <= 5'h00;
    else if ($fell(sclk))
      n_fall <= n_fall + 5'h01;
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || frame_sel_n)
      spent <= 1'b0;
    else if (o_frame_done)
      spent <= 1'b1;
  end
  sequence s_gap;
    frame_sel_n ##1 frame_sel_n;
  endsequence
  a_sel_gap_min: assert property ($rose(frame_sel_n) |-> s_gap)
    else $error("select high too short");
  a_sclk_half_min: assert property ($changed(sclk) |=> $stable(sclk))
    else $error("serial clock too fast");
  a_sclk_quiet_idle: assert property (frame_sel_n |-> !$fell(sclk))
    else $error("clock fell while deselected");
  a_done_count: assert property (o_frame_done |-> n_fall == 5'h10)
    else $error("frame done without sixteen falls");
  a_done_once: assert property (spent |-> !o_frame_done)
    else $error("second execution in one selection");
  a_done_selected: assert property (o_frame_done |-> !frame_sel_n)
    else $error("execution while deselected");
  a_state_together: assert property
    (($changed(o_code) || $changed(o_mode)) |-> o_frame_done)
    else $error("code or mode moved outside execution");
  a_mode_switches: assert property ($stable(o_mode) |->
    o_amp_connect == (o_mode == dacswp_pkg::DACSWP_MODE_NORMAL) &&
    o_pull_1k == (o_mode == dacswp_pkg::DACSWP_MODE_PD_1K) &&
    o_pull_100k == (o_mode == dacswp_pkg::DACSWP_MODE_PD_100K))
    else $error("output switches disagree with mode");
endmodule : dacswp_monitor

// *** sim/test_dacswp.sv ***
// Bench: host and device joined over one link, plus a second device
// driven directly to try aborted and overlong frames.
`timescale 1ns/1ps
module test_dacswp;
  logic                     i_mclk, i_rst, i_wr, i_rd, sclk_q, sd_q;
  logic [1:0]               i_addr;
  logic [31:0]              i_wdata, o_rdata;
  logic [11:0]              code, code2;
  dacswp_pkg::dacswp_mode_t mode, mode2;
  logic [4095:0]            tap;
  logic                     amp, p1k, p100k, done;
  logic [15:0]              cap;
  int                       n_errors = 0, n_tests = 0, n_done = 0;
  dacswp_if lk();
  dacswp_if lk2();
  dacswp_host dacswp_host_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(lk.host));
  dacswp_device dacswp_device_i (.i_mclk(i_mclk), .i_rst(i_rst), .link(lk.dev),
    .o_code(code), .o_mode(mode), .o_tap_sel(tap), .o_amp_connect(amp),
    .o_pull_1k(p1k), .o_pull_100k(p100k), .o_frame_done(done));
  // Second device faces the bench, which breaks the framing on purpose
  dacswp_device dacswp_device_b_i (.i_mclk(i_mclk), .i_rst(i_rst), .link(lk2.dev),
    .o_code(code2), .o_mode(mode2), .o_tap_sel(), .o_amp_connect(),
    .o_pull_1k(), .o_pull_100k(), .o_frame_done());
  dacswp_monitor dacswp_monitor_i (.i_mclk(i_mclk), .i_rst(i_rst),
    .frame_sel_n(lk.frame_sel_n), .sclk(lk.sclk), .o_code(code), .o_mode(mode),
    .o_amp_connect(amp), .o_pull_1k(p1k), .o_pull_100k(p100k), .o_frame_done(done));
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Wire bits taken one cycle before each fall, where data is settled
  always @(posedge i_mclk)
  begin
    n_done <= n_done + ((done === 1'b1) ? 1 : 0);
    cap <= lk.frame_sel_n ? 16'h0 : ((sclk_q && !lk.sclk) ? {cap[14:0], sd_q} : cap);
    sclk_q <= lk.sclk;
    sd_q <= lk.sdata;
  end
  task end_sim;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask : wr
  task rd(input logic [1:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
    d = o_rdata;
  endtask : rd
  task go(input logic [13:0] c);
    logic [31:0] st;
    int          k;
    k = n_done;
    st = 32'h1;
    wr(2'h0, {18'h0, c});
    for (int t = 0; t < 200 && (n_done == k || st[0] !== 1'b0); t++)
      rd(2'h1, st);
    if (n_done == k || st[0] !== 1'b0)
    begin
      n_errors++;
      end_sim();
    end
  endtask : go
  task send(input logic [31:0] w, input int n);
    lk2.frame_sel_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    for (int i = 0; i < n; i++)
    begin
      lk2.sdata <= w[31-i];
      repeat (4) @(posedge i_mclk);
      lk2.sclk <= 1'b0;
      repeat (4) @(posedge i_mclk);
      lk2.sclk <= 1'b1;
    end
    repeat (8) @(posedge i_mclk);
    lk2.frame_sel_n <= 1'b1;
    lk2.sdata <= ~lk2.sdata;
    lk2.sclk <= 1'b0;
    repeat (4) @(posedge i_mclk);
    lk2.sclk <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask : send
  task t_modes;
    logic [31:0] r;
    logic [11:0] c;
    for (int m = 0; m < 4; m++)
    begin
      c = 12'hfff >> (4 * m);
      go({2'(m), c});
      chk({2'h0, mode, code}, {2'h0, 2'(m), c});
      chk(cap, {2'h0, 2'(m), c});
      chk({amp, p1k, p100k}, {m == 0, m == 1, m == 2});
      chk(16'(tap == (4096'h1 << c)), 16'h1);
      rd(2'h0, r);
      chk(r[15:0], 16'h0);
    end
  endtask : t_modes
  task t_refuse;
    int          k;
    logic [31:0] r;
    k = n_done;
    wr(2'h2, 32'h1555);
    wr(2'h0, 32'h0123);
    rd(2'h0, r);
    chk(r[15:0], 16'h0123);
    go(14'h2abc);
    chk(16'(n_done - k), 16'h1);
    chk({2'h0, mode, code}, 16'h0123);
  endtask : t_refuse
  task t_far;
    send({16'hc5a5, 16'h0}, 16);
    chk({2'h0, mode2, code2}, 16'h05a5);
    send({16'h3abc, 16'h0}, 15);
    chk({2'h0, mode2, code2}, 16'h05a5);
    send({16'h2123, 16'h1fff}, 32);
    chk({2'h0, mode2, code2}, 16'h2123);
  endtask : t_far
  initial
  begin
    {i_rst, i_addr, i_wdata, i_wr, i_rd} <= {1'b1, 36'h0};
    {lk2.frame_sel_n, lk2.sclk, lk2.sdata} <= 3'h6;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    chk({2'h0, mode, code}, 16'h0);
    chk({tap[0], amp, p1k, p100k, code2}, 16'hc000);
    chk({14'h0, mode2}, 16'h0);
    chk(16'(tap == 4096'h1), 16'h1);
    t_modes();
    t_refuse();
    t_far();
    end_sim();
  end
endmodule : test_dacswp
